// ### hw/asoc_cfg.svh
`ifndef ASOC_CFG_SVH
`define ASOC_CFG_SVH

////////////////////////////////////////////////////////////////////////////////
// Register indices; byte address is four times the index
`define ASOC_IDX_FAULT_EN    8'h18
`define ASOC_IDX_INC_CFG     8'h19
`define ASOC_IDX_ERR_MASK    8'h1a
`define ASOC_IDX_IFACE_CFG   8'h1b
`define ASOC_REG_W           24

////////////////////////////////////////////////////////////////////////////////
// Reset values and writable bits
`define ASOC_RST_FAULT_EN    24'h00_0000
`define ASOC_RST_INC_CFG     24'h00_0000
`define ASOC_RST_ERR_MASK    24'h00_0000
`define ASOC_RST_IFACE_CFG   24'h00_0000
`define ASOC_WM_FAULT_EN     24'h00_0fff
`define ASOC_WM_INC_CFG      24'h3f_93ff
`define ASOC_WM_ERR_MASK     24'hdf_6fff
`define ASOC_WM_IFACE_CFG    24'hff_7fff

////////////////////////////////////////////////////////////////////////////////
// Incremental output configuration fields
`define ASOC_RES_LSB         0
`define ASOC_UVW_BIT         4
`define ASOC_IOE_BIT         5
`define ASOC_PLH_BIT         6
`define ASOC_WDH_BIT         7
`define ASOC_IDX_MODE_LSB    8
`define ASOC_AHE_BIT         12
`define ASOC_INV_BIT         15
`define ASOC_SLEW_LSB        16

////////////////////////////////////////////////////////////////////////////////
// Mask and interface/linearization fields
`define ASOC_WARM_BIT        11
`define ASOC_SC_BIT          0
`define ASOC_S17_BIT         1
`define ASOC_DM_BIT          3
`define ASOC_ZAL_BIT         7
`define ASOC_LS_BIT          10
`define ASOC_ELI_BIT         11
`define ASOC_PES_BIT         12
`define ASOC_PEO_BIT         13
`define ASOC_PEN_BIT         23

////////////////////////////////////////////////////////////////////////////////
// Fault duty in 1/1600 units: 5 % plus 5.625 % per priority step
`define ASOC_DUTY_BASE       11'd80
`define ASOC_DUTY_STEP       11'd90
`define ASOC_DUTY_DEN        11'd1600
`define ASOC_HYST_LSB        4

////////////////////////////////////////////////////////////////////////////////
// Timing
`define ASOC_CLK_NS          10
`define ASOC_SLEW_UNIT_NS    125

`endif

// ### hw/asoc_pkg.sv
package asoc_pkg;

  typedef enum logic [1:0]
  {
    PWM_NORMAL = 2'b00,
    PWM_FAULT  = 2'b01,
    PWM_HIZ    = 2'b10
  } asoc_pwm_e;

  typedef logic [23:0] asoc_word_t;

endpackage : asoc_pkg

// ### hw/asoc_quad_step.sv
`timescale 1ns/1ps
module asoc_quad_step
  import asoc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  asoc_step_if.step sif
);

  logic [1:0] cur;
  logic [1:0] next_cur;
  logic [9:0] cnt;
  logic [9:0] next_cnt;

  // One quadrature step at a time toward the target, spaced by gap cycles
  always_comb
  begin
    next_cur = cur;
    next_cnt = (cnt != 10'h000) ? cnt - 10'h001 : cnt;
    if ((cur != sif.target) && (cnt == 10'h000))
    begin
      next_cur = (2'(sif.target - cur) == 2'h3) ? cur - 2'h1 : cur + 2'h1;
      next_cnt = (sif.gap != 10'h000) ? sif.gap - 10'h001 : 10'h000;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cur <= 2'h0;
      cnt <= 10'h000;
    end
    else
    begin
      cur <= next_cur;
      cnt <= next_cnt;
    end
  end

  assign sif.state = cur;

  slew_gap_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cur != $past(cur)) |-> ($past(cnt) == 10'h000))
    else $error("quadrature edge inside slew gap");

  slew_seen_c: cover property (@(posedge pclk) disable iff (!presetn)
    (cnt == 10'h001) ##1 (cur != $past(cur)));

endmodule : asoc_quad_step

// ### hw/asoc_step_if.sv
`timescale 1ns/1ps
interface asoc_step_if;
  logic [1:0] target;
  logic [9:0] gap;
  logic [1:0] state;

  modport ctl
  (
    output target,
    output gap,
    input  state
  );

  modport step
  (
    input  target,
    input  gap,
    output state
  );
endinterface : asoc_step_if

// ### hw/asoc_top.sv
`timescale 1ns/1ps
`include "asoc_cfg.svh"
// How it works
// - First three faults give 5-16.25 % duty
// - Next three faults give 21.875-33.125 % duty
// - Next three faults give 38.75-50 % duty
// - Last three faults give 55.625-66.875 % duty
// - Fault duty runs at half carrier frequency
// - Quadrature gives 2^(14-n) cycles per turn
// - Commutation code is pole pairs minus one
// - Select bit picks commutation or quadrature
// - Incremental pins driven only when enabled
// - PLL unlock forces outputs high before inversion
// - Watchdog trip forces outputs high before inversion
// - Index mode sets index placement and width
// - Hysteresis applied to incremental angle
// - Inversion bit flips incremental output polarity
// - Nonzero slew field spaces quadrature A/B edges (N+1)x125ns
// - Mask bit removes source from summary flag
// - Warning mask suppresses warning summary bit
// - Serial CRC check follows its enable
// - Extra edge ignore passed to serial slave
// - Manchester input ignored when disabled
// - Offset position bit orders offset subtraction
// - Linearization enable and range select
// - Fault response: tristate latch or fault duty
module asoc_top
  import asoc_pkg::*;
#(
  parameter int HYST_LSB = `ASOC_HYST_LSB
)(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [9:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        nvm_load_valid,
  input  wire logic [1:0]  nvm_load_idx,
  input  wire logic [23:0] nvm_load_data,
  input  wire logic [11:0] pwm_err_src,
  input  wire logic [23:0] err_src,
  input  wire logic        warn_present,
  input  wire logic        pll_unlock,
  input  wire logic        hf_watchdog,
  input  wire logic [13:0] angle,
  output logic             pwm_err_active,
  output logic             pwm_half_freq,
  output logic      [10:0] pwm_duty,
  output logic             pwm_tristate,
  output logic             inc_a_u,
  output logic             inc_b_v,
  output logic             inc_i_w,
  output logic             inc_oe,
  output logic             summary_error_flag,
  output logic             warning_summary_bit,
  output logic             spi_crc_check_on,
  output logic             extra_edge_ignore,
  output logic             manchester_in_disable,
  output logic             offset_after_lin,
  output logic             lin_enable,
  output logic             correction_range_select
);

  //////////////////////////////////////////////////////////////////////////////
  // Register decode

  // Hit flag and word index for a byte address
  function automatic logic [2:0] reg_sel(input logic [9:0] a);
    logic [7:0] idx;
    idx = a[9:2];
    reg_sel = {(idx >= `ASOC_IDX_FAULT_EN) && (idx <= `ASOC_IDX_IFACE_CFG), 2'(idx)};
  endfunction : reg_sel

  function automatic asoc_word_t wmask(input logic [1:0] i);
    case (i)
      2'h0:    wmask = `ASOC_WM_FAULT_EN;
      2'h1:    wmask = `ASOC_WM_INC_CFG;
      2'h2:    wmask = `ASOC_WM_ERR_MASK;
      default: wmask = `ASOC_WM_IFACE_CFG;
    endcase
  endfunction : wmask

  // Commutation pattern for one of six electrical sectors
  function automatic logic [2:0] uvw_tab(input logic [2:0] s);
    case (s)
      3'h0:    uvw_tab = 3'b100;
      3'h1:    uvw_tab = 3'b110;
      3'h2:    uvw_tab = 3'b010;
      3'h3:    uvw_tab = 3'b011;
      3'h4:    uvw_tab = 3'b001;
      default: uvw_tab = 3'b101;
    endcase
  endfunction : uvw_tab

  //////////////////////////////////////////////////////////////////////////////
  // Register bank and APB slave

  asoc_word_t cfg      [4];
  asoc_word_t next_cfg [4];
  logic       [31:0] next_prdata;
  logic              next_pready;
  logic              next_pslverr;
  logic       [2:0]  sel;

  assign sel = reg_sel(paddr);

  always_comb
  begin
    next_cfg     = cfg;
    next_prdata  = prdata;
    next_pready  = psel & penable & ~pready;
    next_pslverr = 1'b0;
    if (nvm_load_valid)
    begin
      next_cfg[nvm_load_idx] = nvm_load_data & wmask(nvm_load_idx);
    end
    if (psel && penable && pready && pwrite && sel[2])
    begin
      next_cfg[sel[1:0]] = pwdata[23:0] & wmask(sel[1:0]);
    end
    if (psel && penable && !pready)
    begin
      next_prdata  = (sel[2] && !pwrite) ? {8'h00, cfg[sel[1:0]]} : 32'h0000_0000;
      next_pslverr = ~sel[2];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg[0]  <= `ASOC_RST_FAULT_EN;
      cfg[1]  <= `ASOC_RST_INC_CFG;
      cfg[2]  <= `ASOC_RST_ERR_MASK;
      cfg[3]  <= `ASOC_RST_IFACE_CFG;
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      cfg     <= next_cfg;
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Field views

  asoc_word_t fen;
  asoc_word_t inc;
  asoc_word_t msk;
  asoc_word_t ifc;
  logic [3:0] res;
  logic [5:0] slew;

  assign fen  = cfg[0];
  assign inc  = cfg[1];
  assign msk  = cfg[2];
  assign ifc  = cfg[3];
  assign res  = inc[`ASOC_RES_LSB +: 4];
  assign slew = inc[`ASOC_SLEW_LSB +: 6];

  //////////////////////////////////////////////////////////////////////////////
  // Pulse-output fault response

  asoc_pwm_e   pwm_state;
  asoc_pwm_e   next_pwm_state;
  logic [11:0] pwm_hit;
  logic [3:0]  pri;
  logic        err_any;
  logic        next_pwm_err_active;
  logic        next_pwm_half_freq;
  logic [10:0] next_pwm_duty;
  logic        next_pwm_tristate;

  assign pwm_hit = pwm_err_src & fen[11:0];
  assign err_any = |pwm_hit;

  // Lowest enabled source number has priority
  always_comb
  begin
    pri = 4'h0;
    for (int i = 11; i >= 0; i--)
    begin
      if (pwm_hit[i])
      begin
        pri = 4'(i);
      end
    end
  end

  always_comb
  begin
    next_pwm_state = pwm_state;
    case (pwm_state)
      PWM_NORMAL:
      begin
        if (ifc[`ASOC_PEO_BIT] && err_any)
        begin
          next_pwm_state = ifc[`ASOC_PES_BIT] ? PWM_FAULT : PWM_HIZ;
        end
      end
      PWM_FAULT:
      begin
        if (!(ifc[`ASOC_PEO_BIT] && err_any))
        begin
          next_pwm_state = PWM_NORMAL;
        end
        else if (!ifc[`ASOC_PES_BIT])
        begin
          next_pwm_state = PWM_HIZ;
        end
      end
      PWM_HIZ:
      begin
        // Latched until reset or until the response enable is cleared
        if (!ifc[`ASOC_PEO_BIT])
        begin
          next_pwm_state = PWM_NORMAL;
        end
      end
      default: next_pwm_state = PWM_NORMAL;
    endcase
    next_pwm_err_active = (next_pwm_state == PWM_FAULT);
    next_pwm_half_freq  = (next_pwm_state == PWM_FAULT);
    next_pwm_duty       = 11'h000;
    if (next_pwm_state == PWM_FAULT)
    begin
      next_pwm_duty = 11'(`ASOC_DUTY_BASE + `ASOC_DUTY_STEP * 11'(pri));
    end
    next_pwm_tristate = (next_pwm_state == PWM_HIZ) | ~ifc[`ASOC_PEN_BIT];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pwm_state      <= PWM_NORMAL;
      pwm_err_active <= 1'b0;
      pwm_half_freq  <= 1'b0;
      pwm_duty       <= 11'h000;
      pwm_tristate   <= 1'b1;
    end
    else
    begin
      pwm_state      <= next_pwm_state;
      pwm_err_active <= next_pwm_err_active;
      pwm_half_freq  <= next_pwm_half_freq;
      pwm_duty       <= next_pwm_duty;
      pwm_tristate   <= next_pwm_tristate;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Incremental outputs

  logic        [13:0] held;
  logic        [13:0] next_held;
  logic signed [13:0] adiff;
  logic        [15:0] phase;
  logic        [15:0] pmax;
  logic        [13:0] elec;
  logic        [16:0] sect;
  logic               idx_on;
  logic               force_hi;
  logic        [2:0]  raw;
  logic        [2:0]  next_inc;
  logic               next_inc_oe;

  asoc_step_if sif ();

  asoc_quad_step u_step
  (
    .pclk    (pclk),
    .presetn (presetn),
    .sif     (sif)
  );

  always_comb
  begin
    adiff     = $signed(angle - held);
    next_held = held;
    if (!inc[`ASOC_AHE_BIT] || (adiff > HYST_LSB) || (adiff < -HYST_LSB))
    begin
      next_held = angle;
    end
  end

  assign phase = 16'({held, 2'b00} >> res);
  assign pmax  = 16'hffff >> res;
  assign elec  = 14'(held * ({1'b0, res} + 5'h01));
  assign sect  = 17'(elec * 17'd6);

  assign sif.target = phase[1:0];
  assign sif.gap    = (slew == 6'h00) ? 10'h000 :
    10'(((32'(slew) + 1) * `ASOC_SLEW_UNIT_NS + `ASOC_CLK_NS - 1) / `ASOC_CLK_NS);

  always_comb
  begin
    case (inc[`ASOC_IDX_MODE_LSB +: 2])
      2'h0:    idx_on = (phase == 16'h0000);
      2'h1:    idx_on = (phase == 16'h0000) || (phase == pmax);
      2'h2:    idx_on = (phase <= 16'h0001) || (phase == pmax);
      default: idx_on = (phase <= 16'h0001) || (phase >= pmax - 16'h0001);
    endcase
    force_hi = (inc[`ASOC_PLH_BIT] & pll_unlock) | (inc[`ASOC_WDH_BIT] & hf_watchdog);
    if (inc[`ASOC_UVW_BIT])
    begin
      raw = uvw_tab(sect[16:14]);
    end
    else
    begin
      raw = {sif.state[1], ^sif.state, idx_on};
    end
    next_inc = force_hi ? 3'b111 : raw;
    if (inc[`ASOC_INV_BIT])
    begin
      next_inc = ~next_inc;
    end
    next_inc_oe = inc[`ASOC_IOE_BIT];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      held                        <= 14'h0000;
      {inc_a_u, inc_b_v, inc_i_w} <= 3'b000;
      inc_oe                      <= 1'b0;
    end
    else
    begin
      held                        <= next_held;
      {inc_a_u, inc_b_v, inc_i_w} <= next_inc;
      inc_oe                      <= next_inc_oe;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Error summary and pass-through controls

  logic [23:0] next_flag_src;
  logic        next_summary;
  logic        next_warn;
  logic [5:0]  next_ctl;

  always_comb
  begin
    next_flag_src = err_src & ~msk & `ASOC_WM_ERR_MASK;
    next_flag_src[`ASOC_WARM_BIT] = 1'b0;
    next_summary  = |next_flag_src;
    next_warn     = warn_present & ~msk[`ASOC_WARM_BIT];
    next_ctl      = {ifc[`ASOC_SC_BIT], ifc[`ASOC_S17_BIT], ifc[`ASOC_DM_BIT],
                     ifc[`ASOC_ZAL_BIT], ifc[`ASOC_ELI_BIT], ifc[`ASOC_LS_BIT]};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      summary_error_flag  <= 1'b0;
      warning_summary_bit <= 1'b0;
      {spi_crc_check_on, extra_edge_ignore, manchester_in_disable,
       offset_after_lin, lin_enable, correction_range_select} <= 6'h00;
    end
    else
    begin
      summary_error_flag  <= next_summary;
      warning_summary_bit <= next_warn;
      {spi_crc_check_on, extra_edge_ignore, manchester_in_disable,
       offset_after_lin, lin_enable, correction_range_select} <= next_ctl;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  osc_duty_a: assert property (@(posedge pclk) disable iff (!presetn)
    (next_pwm_state == PWM_FAULT && pwm_hit[0]) |=> (pwm_duty == 11'd80))
    else $error("oscillator fault duty wrong");

  pll_duty_a: assert property (@(posedge pclk) disable iff (!presetn)
    (next_pwm_state == PWM_FAULT && pwm_hit[3] && pwm_hit[2:0] == 3'h0)
    |=> (pwm_duty == 11'd350))
    else $error("pll fault duty wrong");

  uv_duty_a: assert property (@(posedge pclk) disable iff (!presetn)
    (next_pwm_state == PWM_FAULT && pwm_hit[6] && pwm_hit[5:0] == 6'h00)
    |=> (pwm_duty == 11'd620))
    else $error("undervoltage fault duty wrong");

  temp_duty_a: assert property (@(posedge pclk) disable iff (!presetn)
    (next_pwm_state == PWM_FAULT && pwm_hit == 12'h800) |=> (pwm_duty == 11'd1070))
    else $error("temperature fault duty wrong");

  half_freq_a: assert property (@(posedge pclk) disable iff (!presetn)
    pwm_half_freq |-> (pwm_err_active && pwm_duty != 11'h000))
    else $error("half frequency without fault duty");

  hiz_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pwm_state == PWM_HIZ && ifc[`ASOC_PEO_BIT]) |=> (pwm_tristate && pwm_state == PWM_HIZ))
    else $error("tristate latch released");

  force_high_a: assert property (@(posedge pclk) disable iff (!presetn)
    (inc[`ASOC_PLH_BIT] && pll_unlock && !inc[`ASOC_INV_BIT])
    |=> (inc_a_u && inc_b_v && inc_i_w))
    else $error("outputs not forced high");

  pin_en_a: assert property (@(posedge pclk) disable iff (!presetn)
    inc_oe == $past(inc[`ASOC_IOE_BIT]))
    else $error("pin enable mismatch");

  flag_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
    ((err_src & ~msk & 24'hdf_67ff) == 24'h00_0000) |=> !summary_error_flag)
    else $error("masked source raised summary flag");

  war_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
    msk[`ASOC_WARM_BIT] |=> !warning_summary_bit)
    else $error("warning bit set while masked");

  fault_duty_c: cover property (@(posedge pclk) disable iff (!presetn)
    !pwm_err_active ##1 pwm_err_active);

  hiz_c: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(pwm_state == PWM_HIZ));

  uvw_c: cover property (@(posedge pclk) disable iff (!presetn)
    inc[`ASOC_UVW_BIT] && inc_oe);

endmodule : asoc_top

// ### verif/asoc_host_model.sv
`timescale 1ns/1ps
module asoc_host_model
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        clr,
  input wire logic        inc_a_u,
  input wire logic        inc_b_v,
  input wire logic [15:0] gap_req,
  output logic     [15:0] edges,
  output logic            gap_ok
);
  logic        a_q;
  logic        b_q;
  logic [15:0] since;

  // Host decoder: counts A/B edges and flags edges closer than gap_req
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      a_q <= 1'b0;
      b_q <= 1'b0;
      edges <= 16'h0000;
      gap_ok <= 1'b1;
      since <= 16'hffff;
    end
    else
    begin
      a_q <= inc_a_u;
      b_q <= inc_b_v;
      if (clr)
      begin
        edges <= 16'h0000;
        gap_ok <= 1'b1;
        since <= 16'hffff;
      end
      else if ((a_q ^ inc_a_u) || (b_q ^ inc_b_v))
      begin
        edges <= edges + 16'(a_q ^ inc_a_u) + 16'(b_q ^ inc_b_v);
        if (since < gap_req)
          gap_ok <= 1'b0;
        since <= 16'h0001;
      end
      else if (since != 16'hffff)
        since <= since + 16'h0001;
    end
  end
endmodule : asoc_host_model

// ### verif/asoc_top_test.sv
`timescale 1ns/1ps
`include "asoc_cfg.svh"
module asoc_top_test;
  typedef struct {logic [63:0] exp; logic [63:0] msk;} asoc_note_s;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [9:0]  paddr = 10'h000;
  logic [31:0] pwdata = 32'h0000_0000, seed = 32'h0000_fb74;
  logic        nvm_load_valid = 1'b0, warn_present = 1'b0, pll_unlock = 1'b0;
  logic        hf_watchdog = 1'b0, probe = 1'b0, clr = 1'b0;
  logic [1:0]  nvm_load_idx = 2'h0;
  logic [23:0] nvm_load_data = 24'h00_0000, err_src = 24'h00_0000, r, m, e;
  logic [11:0] pwm_err_src = 12'h000;
  logic [13:0] angle = 14'h0000;
  logic [15:0] gap_req = 16'h0000, edges;
  logic [31:0] prdata;
  logic [10:0] pwm_duty;
  logic        pready, pslverr, act, half, tri_o, ia, ib, ii, ioe, sef, wsb, gap_ok;
  logic [5:0]  ifb;
  logic [63:0] obs;
  logic [23:0] wm [4] = '{`ASOC_WM_FAULT_EN, `ASOC_WM_INC_CFG, `ASOC_WM_ERR_MASK,
                          `ASOC_WM_IFACE_CFG};
  asoc_note_s  notes[$];
  int          failures = 0, comparisons = 0, cyc = 0;

  asoc_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .nvm_load_valid(nvm_load_valid), .nvm_load_idx(nvm_load_idx),
    .nvm_load_data(nvm_load_data), .pwm_err_src(pwm_err_src), .err_src(err_src),
    .warn_present(warn_present), .pll_unlock(pll_unlock), .hf_watchdog(hf_watchdog),
    .angle(angle), .pwm_err_active(act), .pwm_half_freq(half), .pwm_duty(pwm_duty),
    .pwm_tristate(tri_o), .inc_a_u(ia), .inc_b_v(ib), .inc_i_w(ii), .inc_oe(ioe),
    .summary_error_flag(sef), .warning_summary_bit(wsb), .spi_crc_check_on(ifb[5]),
    .extra_edge_ignore(ifb[4]), .manchester_in_disable(ifb[3]),
    .offset_after_lin(ifb[2]), .lin_enable(ifb[1]), .correction_range_select(ifb[0]));
  asoc_host_model host_u (.pclk(pclk), .presetn(presetn), .clr(clr), .inc_a_u(ia),
    .inc_b_v(ib), .gap_req(gap_req), .edges(edges), .gap_ok(gap_ok));

  assign obs = {21'h0, edges, gap_ok, act, half, tri_o, pwm_duty, ia, ib, ii, ioe, sef, wsb, ifb};

  ////////////////////////////////////////////////////////////////////////////////
  always #5 pclk = ~pclk;

  always @(posedge pclk)
  begin
    asoc_note_s n;
    logic [63:0] got;
    cyc++;
    if ((psel && penable && pready && !pwrite) || probe)
    begin
      got = probe ? obs : {31'h0, pslverr, prdata};
      n = notes.pop_front();
      comparisons++;
      if ((got & n.msk) !== (n.exp & n.msk))
      begin
        failures++;
        $display("[FAIL] %0t: got %h expected %h", $time, got & n.msk, n.exp & n.msk);
      end
    end
    if (cyc == 20000)
    begin
      failures++;
      tally_and_finish();
    end
  end

  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task settle(input int n);
    repeat (n) @(posedge pclk);
  endtask : settle

  task apb(input logic wr_n, input logic [7:0] idx, input logic [23:0] wd);
    psel <= 1'b1;
    pwrite <= wr_n;
    paddr <= {idx, 2'b00};
    pwdata <= {8'h00, wd};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      @(posedge pclk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task rd(input logic [7:0] idx, input logic [23:0] x, input logic err);
    notes.push_back('{{31'h0, err, 8'h00, x}, {31'h0, 33'h1_ffff_ffff}});
    apb(1'b0, idx, 24'h00_0000);
  endtask : rd

  task chk(input logic [63:0] msk, input logic [63:0] x);
    notes.push_back('{x, msk});
    probe <= 1'b1;
    @(posedge pclk);
    probe <= 1'b0;
    @(posedge pclk);
  endtask : chk

  task sweep(input logic [23:0] cfg, input logic [15:0] n);
    apb(1'b1, 8'h19, cfg);
    angle <= 14'h0000;
    settle(20);
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    for (int i = 1; i <= 256; i++)
    begin
      angle <= 14'(i * 64);
      settle(4);
    end
    settle(20);
    chk(64'hffff << 27, 64'(n) << 27);
  endtask : sweep

  task tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : tally_and_finish

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    settle(20);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 4; i++)
    begin
      rd(8'(8'h18 + i), 24'h00_0000, 1'b0);
      r = 24'(rnd());
      apb(1'b1, 8'(8'h18 + i), r);
      rd(8'(8'h18 + i), r & wm[i], 1'b0);
    end
    apb(1'b1, 8'h1c, 24'hff_ffff);
    rd(8'h1c, 24'h00_0000, 1'b1);
    r = 24'(rnd()) & wm[2];
    nvm_load_valid <= 1'b1;
    nvm_load_idx <= 2'h2;
    nvm_load_data <= r;
    @(posedge pclk);
    nvm_load_valid <= 1'b0;
    rd(8'h1a, r, 1'b0);
    apb(1'b1, 8'h1b, 24'h80_3000);
    apb(1'b1, 8'h18, 24'h00_0fff);
    for (int k = 0; k < 12; k++)
    begin
      pwm_err_src <= 12'hfff << k;
      settle(3);
      chk(64'h3fff << 12, {3'b110, `ASOC_DUTY_BASE + `ASOC_DUTY_STEP * 11'(k)} << 12);
    end
    apb(1'b1, 8'h18, 24'h00_0ffe);
    pwm_err_src <= 12'h001;
    settle(3);
    chk(64'h3fff << 12, 64'h0);
    apb(1'b1, 8'h18, 24'h00_0fff);
    apb(1'b1, 8'h1b, 24'h80_2000);
    settle(3);
    chk(64'h1 << 23, 64'h1 << 23);
    pwm_err_src <= 12'h000;
    settle(3);
    chk(64'h1 << 23, 64'h1 << 23);
    apb(1'b1, 8'h1b, 24'h80_0000);
    settle(3);
    chk(64'h3fff << 12, 64'h0);
    for (int j = 0; j < 6; j++)
    begin
      r = 24'(rnd());
      apb(1'b1, 8'h1b, r);
      settle(3);
      chk(64'h3f, {r[0], r[1], r[3], r[7], r[11], r[10]});
    end
    for (int j = 0; j < 8; j++)
    begin
      m = 24'(rnd());
      e = 24'h1 << (rnd() % 24);
      apb(1'b1, 8'h1a, m);
      err_src <= e;
      warn_present <= seed[7];
      settle(3);
      chk(64'hc0, {|(e & ~m & 24'hdf_67ff), seed[7] & ~m[11], 6'h0});
    end
    err_src <= 24'h00_0000;
    for (int j = 0; j < 4; j++)
    begin
      apb(1'b1, 8'h19, 24'h00_00e0 | (24'(j[0]) << 15));
      pll_unlock <= ~j[1];
      hf_watchdog <= j[1];
      settle(4);
      chk(64'hf00, {{3{~j[0]}}, 1'b1, 8'h00});
    end
    pll_unlock <= 1'b0;
    hf_watchdog <= 1'b0;
    apb(1'b1, 8'h19, 24'h00_0000);
    settle(3);
    chk(64'h100, 64'h0);
    sweep(24'h00_002a, 16'd64);
    sweep(24'h00_0031, 16'd8);
    apb(1'b1, 8'h19, 24'h00_102a);
    settle(3);
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    angle <= 14'h3ffe;
    settle(10);
    chk(64'hffff << 27, 64'h0);
    angle <= 14'h0000;
    apb(1'b1, 8'h19, 24'h07_002a);
    gap_req <= 16'd100;
    settle(20);
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    angle <= 14'h0200;
    settle(1200);
    chk(64'h1ffff << 26, 64'h5 << 26);
    tally_and_finish();
  end
endmodule : asoc_top_test
